// File: logic/fpm_array.sv
/*
  Program memory array: word read, row erase and row program from the latches.
  Assumes the sequencer never asks for erase and program in the same cycle.
*/
`timescale 1ns/1ps
module fpm_array #(
    parameter int DEPTH = 4096
) (
    // Clock
    input wire logic clk,
    // Sequencer side
    fpm_mem_if.mem bus
);
    logic [13:0] mem [DEPTH];

    // Contents are not reset: a real array keeps them across reset
    always_ff @(posedge clk) begin
        if (bus.rd_en) begin
            bus.rd_data <= mem[bus.rd_addr];
        end
        if (bus.erase_en) begin
            for (int i = 0; i < fpm_pkg::ROW_WORDS; i++) begin
                mem[{bus.row, i[4:0]}] <= fpm_pkg::ERASED_WORD;
            end
        end else if (bus.prog_en) begin
            for (int i = 0; i < fpm_pkg::ROW_WORDS; i++) begin
                mem[{bus.row, i[4:0]}] <= mem[{bus.row, i[4:0]}] & bus.latch[i];
            end
        end
    end
endmodule

// File: logic/fpm_mem_if.sv
/*
  Carrier between the sequencer and the program memory array.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface fpm_mem_if #(parameter int AW = fpm_pkg::MEM_AW);
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [13:0] rd_data;
    logic erase_en;
    logic prog_en;
    logic [AW-6:0] row;
    logic [13:0] latch [32];

    modport ctrl (output rd_en, rd_addr, erase_en, prog_en, row, latch, input rd_data);
    modport mem (input rd_en, rd_addr, erase_en, prog_en, row, latch, output rd_data);
endinterface

// File: logic/fpm_pkg.sv
/*
  Constants, register map and state codes of the program memory self-access block.
  Assumes a single system clock and an active-low asynchronous reset in every user.
*/
// Overview of operation
// - Program memory is rows of 14-bit words; a row is the least erasable unit.
// - A row holds 32 words and starts where the low five address bits are zero.
// - Thirty-two write latches sit on the same five-bit aligned boundary.
// - Writes and erases happen only outside the write-protected segment.
// - Hidden 14-bit latches are filled only by writes through the data register pair.
// - An erased row may be reprogrammed whole or in part.
// - The second cycle after the read request is the access; that instruction is dropped.
// - The fetched word lands in the data pair right after the access.
// - The data pair holds the word until another read or a software write.
// - Reads return memory contents whatever the code protection setting.
package fpm_pkg;
    localparam int REG_AW = 3;
    localparam logic [2:0] OFF_ADDR_LOW = 3'h0;
    localparam logic [2:0] OFF_ADDR_HIGH = 3'h1;
    localparam logic [2:0] OFF_DATA_LOW = 3'h2;
    localparam logic [2:0] OFF_DATA_HIGH = 3'h3;
    localparam logic [2:0] OFF_CONTROL = 3'h4;

    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_WREN = 2;
    localparam int CTL_WRERR = 3;
    localparam int CTL_ROW_ERASE = 4;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_CFG_SEL = 6;
    localparam int CTL_PGM_SEL = 7;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
    localparam logic [5:0] DATA_HIGH_RESET = 6'h00;

    localparam int WORD_W = 14;
    localparam int MEM_AW = 12;
    localparam int ROW_BITS = 5;
    localparam int ROW_WORDS = 32;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;

    // Lowest unprotected word for each write_protect_field code
    localparam logic [12:0] PROT_LIMIT_ALL = 13'h1000;
    localparam logic [12:0] PROT_LIMIT_HALF = 13'h0800;
    localparam logic [12:0] PROT_LIMIT_LOW = 13'h0200;
    localparam logic [12:0] PROT_LIMIT_NONE = 13'h0000;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_ACCESS = 6'h04,
        ST_LOAD = 6'h08,
        ST_PROG = 6'h10,
        ST_COMMIT = 6'h20
    } fpm_state_type;
endpackage

// File: logic/fpm_top.sv
/*
  Program memory self-access sequencer: address, data and control registers,
  write latches, read timing with instruction suppression, erase and program.
  Assumes a register master that uses one-cycle strobes and never overlaps them,
  and configuration pins that are static but not synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
module fpm_top #(
    parameter int DEPTH = 4096
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Configuration word pins
    input wire logic [1:0] WRITE_PROTECT,
    // Core side
    output logic INSN_SUPPRESS
);
    fpm_pkg::fpm_state_type state;
    fpm_pkg::fpm_state_type next_state;

    logic [1:0] wp_meta;
    logic [1:0] wp_sync;
    logic [7:0] nv_addr_low;
    logic [6:0] nv_addr_high;
    logic [7:0] nv_data_low;
    logic [5:0] nv_data_high;
    logic [7:0] nv_control_one;
    logic [7:0] next_control;
    logic [13:0] latch [fpm_pkg::ROW_WORDS];

    fpm_mem_if #(.AW(fpm_pkg::MEM_AW)) mem_bus ();

    fpm_array #(.DEPTH(DEPTH)) u_array (
        .clk(SYS_CLK),
        .bus(mem_bus)
    );

    function automatic logic hit(input logic [2:0] a, input logic [2:0] off, input logic strobe);
        hit = strobe && (a == off);
    endfunction

    function automatic logic [12:0] prot_limit(input logic [1:0] field);
        case (field)
            2'h0: prot_limit = fpm_pkg::PROT_LIMIT_ALL;
            2'h1: prot_limit = fpm_pkg::PROT_LIMIT_HALF;
            2'h2: prot_limit = fpm_pkg::PROT_LIMIT_LOW;
            default: prot_limit = fpm_pkg::PROT_LIMIT_NONE;
        endcase
    endfunction

    wire wr_addr_low = hit(ADDR, fpm_pkg::OFF_ADDR_LOW, WR);
    wire wr_addr_high = hit(ADDR, fpm_pkg::OFF_ADDR_HIGH, WR);
    wire wr_data_low = hit(ADDR, fpm_pkg::OFF_DATA_LOW, WR);
    wire wr_data_high = hit(ADDR, fpm_pkg::OFF_DATA_HIGH, WR);
    wire wr_control = hit(ADDR, fpm_pkg::OFF_CONTROL, WR);
    wire idle = (state == fpm_pkg::ST_IDLE);
    wire [11:0] word_addr = {nv_addr_high[3:0], nv_addr_low};
    wire [13:0] data_word = {nv_data_high, nv_data_low};
    wire [4:0] latch_index = nv_addr_low[4:0];

    // only a program-space read or write request with config space off starts
    wire pgm_space = WDATA[fpm_pkg::CTL_PGM_SEL] && !WDATA[fpm_pkg::CTL_CFG_SEL];
    wire start_rd = wr_control && idle && pgm_space && WDATA[fpm_pkg::CTL_RD];
    wire start_wr = wr_control && idle && pgm_space && !WDATA[fpm_pkg::CTL_RD]
        && WDATA[fpm_pkg::CTL_WR] && WDATA[fpm_pkg::CTL_WREN];

    // protected below the limit chosen by the field
    wire prot_hit = ({1'b0, word_addr} < prot_limit(wp_sync));
    wire op_ok = !prot_hit && nv_control_one[fpm_pkg::CTL_WREN];
    wire in_prog = (state == fpm_pkg::ST_PROG);
    wire do_erase = in_prog && nv_control_one[fpm_pkg::CTL_ROW_ERASE] && op_ok;
    wire do_latch = in_prog && !nv_control_one[fpm_pkg::CTL_ROW_ERASE];
    wire go_commit = do_latch && op_ok && !nv_control_one[fpm_pkg::CTL_LATCH_ONLY];
    wire set_err = in_prog && prot_hit;

    // row index drops the five aligned low bits
    assign mem_bus.row = word_addr[11:5];
    assign mem_bus.rd_addr = word_addr;
    // no code-protect term gates the read path
    assign mem_bus.rd_en = (state == fpm_pkg::ST_ACCESS);
    assign mem_bus.erase_en = do_erase;
    assign mem_bus.prog_en = (state == fpm_pkg::ST_COMMIT);
    assign mem_bus.latch = latch;

    wire [7:0] read_mux =
        (ADDR == fpm_pkg::OFF_ADDR_LOW) ? nv_addr_low :
        (ADDR == fpm_pkg::OFF_ADDR_HIGH) ? {1'b0, nv_addr_high} :
        (ADDR == fpm_pkg::OFF_DATA_LOW) ? nv_data_low :
        (ADDR == fpm_pkg::OFF_DATA_HIGH) ? {2'b00, nv_data_high} :
        (ADDR == fpm_pkg::OFF_CONTROL) ? nv_control_one : fpm_pkg::BYTE_RESET;

    // Sequencer: read takes WAIT, ACCESS, LOAD; write takes PROG and maybe COMMIT
    always_comb begin
        case (state)
            fpm_pkg::ST_IDLE: begin
                if (start_rd) begin
                    next_state = fpm_pkg::ST_WAIT;
                end else if (start_wr) begin
                    next_state = fpm_pkg::ST_PROG;
                end else begin
                    next_state = fpm_pkg::ST_IDLE;
                end
            end
            fpm_pkg::ST_WAIT: next_state = fpm_pkg::ST_ACCESS;
            fpm_pkg::ST_ACCESS: next_state = fpm_pkg::ST_LOAD;
            fpm_pkg::ST_PROG: next_state = go_commit ? fpm_pkg::ST_COMMIT : fpm_pkg::ST_IDLE;
            default: next_state = fpm_pkg::ST_IDLE;
        endcase
    end

    // Hardware clears request bits; error set wins over a software clear
    always_comb begin
        next_control = nv_control_one;
        if (wr_control) begin
            next_control = WDATA;
            next_control[fpm_pkg::CTL_RD] = nv_control_one[fpm_pkg::CTL_RD] | start_rd;
            next_control[fpm_pkg::CTL_WR] = nv_control_one[fpm_pkg::CTL_WR] | start_wr;
        end
        // read request bit drops as the data pair loads
        if (state == fpm_pkg::ST_LOAD) begin
            next_control[fpm_pkg::CTL_RD] = 1'b0;
        end
        if ((in_prog && !go_commit) || state == fpm_pkg::ST_COMMIT) begin
            next_control[fpm_pkg::CTL_WR] = 1'b0;
        end
        if (set_err) begin
            next_control[fpm_pkg::CTL_WRERR] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wp_meta <= 2'h0;
            wp_sync <= 2'h0;
        end else begin
            wp_meta <= WRITE_PROTECT;
            wp_sync <= wp_meta;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= fpm_pkg::ST_IDLE;
            nv_control_one <= fpm_pkg::CONTROL_RESET;
        end else begin
            state <= next_state;
            nv_control_one <= next_control;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            nv_addr_low <= fpm_pkg::BYTE_RESET;
            nv_addr_high <= fpm_pkg::ADDR_HIGH_RESET;
        end else begin
            if (wr_addr_low) begin
                nv_addr_low <= WDATA;
            end
            if (wr_addr_high) begin
                nv_addr_high <= WDATA[6:0];
            end
        end
    end

    // fetched word loads into the pair; else only software writes
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            nv_data_low <= fpm_pkg::BYTE_RESET;
            nv_data_high <= fpm_pkg::DATA_HIGH_RESET;
        end else if (state == fpm_pkg::ST_LOAD) begin
            nv_data_low <= mem_bus.rd_data[7:0];
            nv_data_high <= mem_bus.rd_data[13:8];
        end else begin
            if (wr_data_low) begin
                nv_data_low <= WDATA;
            end
            if (wr_data_high) begin
                nv_data_high <= WDATA[5:0];
            end
        end
    end

    // one latch per word of the aligned row
    // filled only from the data pair
    generate
        for (genvar g = 0; g < fpm_pkg::ROW_WORDS; g++) begin : g_latch
            always_ff @(posedge SYS_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    latch[g] <= fpm_pkg::ERASED_WORD;
                end else if (state == fpm_pkg::ST_COMMIT) begin
                    latch[g] <= fpm_pkg::ERASED_WORD;
                end else if (do_latch && latch_index == 5'(g)) begin
                    latch[g] <= data_word;
                end
            end
            a_latch_quiet: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
                (!do_latch && state != fpm_pkg::ST_COMMIT) |=> $stable(latch[g]))
                else $error("write latch changed without a load");
            a_latch_release: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
                state == fpm_pkg::ST_COMMIT |=> latch[g] == fpm_pkg::ERASED_WORD)
                else $error("write latch not released after commit");
        end
    endgenerate

    // the dropped instruction matches the access cycle
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            INSN_SUPPRESS <= 1'b0;
            RDATA <= fpm_pkg::BYTE_RESET;
        end else begin
            INSN_SUPPRESS <= (next_state == fpm_pkg::ST_ACCESS);
            RDATA <= RD ? read_mux : fpm_pkg::BYTE_RESET;
        end
    end

    a_read_slot: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        start_rd |=> !INSN_SUPPRESS ##1 (INSN_SUPPRESS && mem_bus.rd_en) ##1 !INSN_SUPPRESS)
        else $error("read access not in second cycle after request");

    a_suppress_single: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(INSN_SUPPRESS) |=> !INSN_SUPPRESS && state == fpm_pkg::ST_LOAD)
        else $error("instruction suppression longer than one cycle");

    a_data_loaded: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        state == fpm_pkg::ST_LOAD |=> {nv_data_high, nv_data_low} == $past(mem_bus.rd_data))
        else $error("data pair not loaded after access");

    a_data_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (state != fpm_pkg::ST_LOAD && !wr_data_low && !wr_data_high)
        |=> $stable(nv_data_low) && $stable(nv_data_high))
        else $error("data pair changed without read or write");

    a_rd_bit_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        start_rd |=> nv_control_one[fpm_pkg::CTL_RD] [*3] ##1 !nv_control_one[fpm_pkg::CTL_RD])
        else $error("read request bit not cleared after load");

    a_protect_block: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (in_prog && prot_hit) |-> !mem_bus.erase_en ##1
        (nv_control_one[fpm_pkg::CTL_WRERR] && !mem_bus.prog_en))
        else $error("protected row was erased or programmed");

    a_latch_store: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (do_latch && !go_commit) |=> latch[$past(latch_index)] == $past(data_word))
        else $error("write latch not loaded from data pair");

    a_program_row: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        go_commit |=> mem_bus.prog_en ##1 (latch[0] == fpm_pkg::ERASED_WORD && idle
        && !nv_control_one[fpm_pkg::CTL_WR]))
        else $error("row program or latch release missing");

    a_erase_row: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        mem_bus.erase_en |-> nv_control_one[fpm_pkg::CTL_ROW_ERASE] && !prot_hit
        ##1 (idle && !nv_control_one[fpm_pkg::CTL_WR]))
        else $error("erase without request or not finished");

    // A read is the longest job, so a stuck sequencer shows up as a long busy run
    logic [2:0] busy_cycles;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_cycles <= 3'h0;
        end else if (idle) begin
            busy_cycles <= 3'h0;
        end else if (busy_cycles != 3'h7) begin
            busy_cycles <= 3'(busy_cycles + 3'h1);
        end
    end

    a_busy_bound: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        busy_cycles <= 3'h3)
        else $error("sequencer stayed busy too long");

    a_access_once: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        mem_bus.rd_en |=> !mem_bus.rd_en && !INSN_SUPPRESS)
        else $error("memory access longer than one cycle");

    a_err_sticky: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (nv_control_one[fpm_pkg::CTL_WRERR] && !wr_control) |=> nv_control_one[fpm_pkg::CTL_WRERR])
        else $error("write error flag lost without a software clear");

    a_commit_allowed: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        mem_bus.prog_en |-> $past(op_ok))
        else $error("row programmed without permission");

    a_cfg_refused: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (wr_control && idle && WDATA[fpm_pkg::CTL_CFG_SEL]) |=> (idle && !nv_control_one[fpm_pkg::CTL_RD]
        && !nv_control_one[fpm_pkg::CTL_WR]))
        else $error("config space request was started");

    a_write_done: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        start_wr |=> nv_control_one[fpm_pkg::CTL_WR] ##1
        (state == fpm_pkg::ST_COMMIT || (idle && !nv_control_one[fpm_pkg::CTL_WR])))
        else $error("write request not finished in time");

    a_rdata_quiet: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !RD |=> RDATA == fpm_pkg::BYTE_RESET)
        else $error("read data shown without a read strobe");
endmodule

// File: testbench/fpm_top_bench.sv
/*
  Self-checking bench for the program memory self-access block: register port,
  row erase, latch loading, row programming, write protection and word reads.
  Assumes fpm_pkg is compiled first; the bench drives every port of fpm_top itself.
*/
`timescale 1ns/1ps
module fpm_top_bench;
    logic SYS_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic [1:0] WRITE_PROTECT = 2'h3;
    logic INSN_SUPPRESS;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam logic [7:0] PGM = 8'h01 << fpm_pkg::CTL_PGM_SEL;
    localparam logic [7:0] CFG = 8'h01 << fpm_pkg::CTL_CFG_SEL;
    localparam logic [7:0] RREQ = 8'h01 << fpm_pkg::CTL_RD;
    localparam logic [7:0] WRITE = PGM | (8'h01 << fpm_pkg::CTL_WR) | (8'h01 << fpm_pkg::CTL_WREN);
    localparam logic [7:0] ERASE = WRITE | (8'h01 << fpm_pkg::CTL_ROW_ERASE);
    localparam logic [7:0] LATCH = WRITE | (8'h01 << fpm_pkg::CTL_LATCH_ONLY);

    fpm_top u_fpm_top (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .WRITE_PROTECT(WRITE_PROTECT), .INSN_SUPPRESS(INSN_SUPPRESS));

    always #12.5 SYS_CLK = ~SYS_CLK;

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("Timeout after %0d cycles", cycles);
            finish_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic set_addr(input logic [11:0] a);
        wr(fpm_pkg::OFF_ADDR_LOW, a[7:0]);
        wr(fpm_pkg::OFF_ADDR_HIGH, {4'h0, a[11:8]});
    endtask

    task automatic set_data(input logic [13:0] w);
        wr(fpm_pkg::OFF_DATA_LOW, w[7:0]);
        wr(fpm_pkg::OFF_DATA_HIGH, {2'h0, w[13:8]});
    endtask

    // Program read with the dropped-instruction slot checked cycle by cycle
    task automatic read_word(input logic [11:0] a, output logic [13:0] w);
        logic [7:0] hi, lo, c;
        // address first, then program space with the read request
        set_addr(a);
        wr(fpm_pkg::OFF_CONTROL, PGM | RREQ);
        // suppression low in the first cycle after the trigger, high in the second, low in the third
        #1 check("suppress c1", {15'h0, INSN_SUPPRESS}, 16'h0000);
        @(posedge SYS_CLK);
        #1 check("suppress c2", {15'h0, INSN_SUPPRESS}, 16'h0001);
        @(posedge SYS_CLK);
        #1 check("suppress c3", {15'h0, INSN_SUPPRESS}, 16'h0000);
        rd(fpm_pkg::OFF_CONTROL, c);
        check("read request cleared", {8'h0, c}, {8'h0, PGM});
        rd(fpm_pkg::OFF_DATA_HIGH, hi);
        rd(fpm_pkg::OFF_DATA_LOW, lo);
        w = {hi[5:0], lo};
    endtask

    // Erase or program, polling the write request bit with a bounded count
    task automatic run_op(input logic [11:0] a, input logic [7:0] ctl, output logic [7:0] v);
        set_addr(a);
        wr(fpm_pkg::OFF_CONTROL, ctl);
        for (int i = 0; i < 8; i++) begin
            rd(fpm_pkg::OFF_CONTROL, v);
            if (v[fpm_pkg::CTL_WR] === 1'b0) break;
        end
        check("write request cleared", {15'h0, v[fpm_pkg::CTL_WR]}, 16'h0000);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0], v);
            check("reset value", {8'h0, v}, 16'h0000);
        end
        @(posedge SYS_CLK);
        #1 check("rdata after read", {8'h0, RDATA}, 16'h0000);
        wr(3'h5, 8'hA5);
        rd(3'h5, v);
        check("unmapped read", {8'h0, v}, 16'h0000);
        wr(fpm_pkg::OFF_ADDR_LOW, 8'h5A);
        rd(fpm_pkg::OFF_ADDR_LOW, v);
        check("addr low back", {8'h0, v}, 16'h005A);
        $display("Test registers done");
    endtask

    // Erase through the last word of a row must clear the whole aligned row
    task automatic t_erase_program();
        logic [7:0] v;
        logic [13:0] w;
        run_op(12'h05F, ERASE, v);
        check("erase error bit", {15'h0, v[fpm_pkg::CTL_WRERR]}, 16'h0000);
        read_word(12'h040, w);
        check("row start erased", {2'h0, w}, {2'h0, fpm_pkg::ERASED_WORD});
        read_word(12'h05F, w);
        check("row end erased", {2'h0, w}, {2'h0, fpm_pkg::ERASED_WORD});
        set_data(14'h2ABC);
        run_op(12'h043, LATCH, v);
        set_data(14'h1555);
        run_op(12'h045, WRITE, v);
        read_word(12'h043, w);
        check("latched word", {2'h0, w}, 16'h2ABC);
        read_word(12'h045, w);
        check("committed word", {2'h0, w}, 16'h1555);
        read_word(12'h044, w);
        check("untouched word", {2'h0, w}, {2'h0, fpm_pkg::ERASED_WORD});
        $display("Test erase and program done");
    endtask

    task automatic t_protect();
        logic [7:0] v;
        logic [13:0] w, saved;
        // keep the programmed word before its row is erased
        read_word(12'h043, saved);
        check("saved word", {2'h0, saved}, 16'h2ABC);
        for (int c = 0; c < 4; c++) begin
            @(posedge SYS_CLK);
            WRITE_PROTECT <= c[1:0];
            repeat (4) @(posedge SYS_CLK);
            run_op(12'h040, ERASE, v);
            check("protect error", {15'h0, v[fpm_pkg::CTL_WRERR]}, {15'h0, c != 3});
            wr(fpm_pkg::OFF_CONTROL, PGM);
            read_word(12'h043, w);
            check("protected content", {2'h0, w}, (c != 3) ? 16'h2ABC : 16'h3FFF);
        end
        // A stale latch would rewrite word 3 of the row here
        set_data(14'h0F0F);
        run_op(12'h041, WRITE, v);
        read_word(12'h041, w);
        check("new word", {2'h0, w}, 16'h0F0F);
        read_word(12'h043, w);
        check("latches emptied", {2'h0, w}, 16'h3FFF);
        set_data(saved);
        run_op(12'h043, WRITE, v);
        read_word(12'h043, w);
        check("restored word", {2'h0, w}, 16'h2ABC);
        $display("Test protection done");
    endtask

    // Data pair holds the fetched word until a software write; a config-space read request is refused
    task automatic t_hold();
        logic [7:0] v;
        logic [13:0] w;
        read_word(12'h041, w);
        repeat (6) @(posedge SYS_CLK);
        rd(fpm_pkg::OFF_DATA_LOW, v);
        check("held low", {8'h0, v}, 16'h000F);
        wr(fpm_pkg::OFF_CONTROL, PGM | CFG | RREQ);
        repeat (4) @(posedge SYS_CLK);
        #1 check("no suppress", {15'h0, INSN_SUPPRESS}, 16'h0000);
        rd(fpm_pkg::OFF_CONTROL, v);
        check("config read refused", {15'h0, v[fpm_pkg::CTL_RD]}, 16'h0000);
        rd(fpm_pkg::OFF_DATA_HIGH, v);
        check("held high", {8'h0, v}, 16'h000F);
        wr(fpm_pkg::OFF_DATA_LOW, 8'h77);
        rd(fpm_pkg::OFF_DATA_LOW, v);
        check("written low", {8'h0, v}, 16'h0077);
        $display("Test hold and refusal done");
    endtask

    // Mid-run reset: registers return to zero while the array keeps its words
    task automatic t_reset();
        logic [7:0] v;
        logic [13:0] w;
        @(posedge SYS_CLK);
        RSTN <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        rd(fpm_pkg::OFF_DATA_LOW, v);
        check("data low after reset", {8'h0, v}, 16'h0000);
        rd(fpm_pkg::OFF_CONTROL, v);
        check("control after reset", {8'h0, v}, 16'h0000);
        read_word(12'h041, w);
        check("word kept over reset", {2'h0, w}, 16'h0F0F);
        $display("Test mid-run reset done");
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        t_regs();
        t_erase_program();
        t_protect();
        t_hold();
        t_reset();
        finish_test();
    end
endmodule
